// File: inc/drlc_regs.svh
// Register offsets, field layout, reset values and timing counts
`ifndef DRLC_REGS_SVH
`define DRLC_REGS_SVH

// ----------------------------------------------------------------------
// Register locations, five-bit word addresses
// ----------------------------------------------------------------------
`define DRLC_ADDR_DAC0      5'h00
`define DRLC_ADDR_DAC1      5'h01
`define DRLC_ADDR_VREF      5'h08
`define DRLC_ADDR_PD        5'h09
`define DRLC_ADDR_GAIN      5'h0a

// ----------------------------------------------------------------------
// Fields and frame layout
// ----------------------------------------------------------------------
`define DRLC_REG_W          16
`define DRLC_DAC_W          12
`define DRLC_FRAME_BITS     24
`define DRLC_CMD_WRITE      2'b00
`define DRLC_CMD_READ       2'b11
`define DRLC_GS_POR_BIT     7
`define DRLC_GS_GAIN_LSB    8
`define DRLC_PD_NORMAL      2'b00
`define DRLC_PD_1K          2'b01
`define DRLC_PD_100K        2'b10
`define DRLC_PD_OPEN        2'b11
`define DRLC_REF_VDD        2'b00
`define DRLC_REF_BANDGAP    2'b01
`define DRLC_REF_UNBUF      2'b10
`define DRLC_REF_BUF        2'b11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DRLC_DAC_MID        12'h7ff
`define DRLC_DAC_ZERO       12'h000
`define DRLC_CFG_ZERO       4'h0
`define DRLC_PD_FORCED      4'hf

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DRLC_CLK_MHZ        250
`define DRLC_RESET_DELAY_NS 10000
`define DRLC_RESET_DELAY_CYC \
  ((`DRLC_RESET_DELAY_NS * `DRLC_CLK_MHZ + 999) / 1000)

`endif

// File: inc/drlc_pkg.sv
// Types for the reset, latch and serial control block
package drlc_pkg;
  `include "drlc_regs.svh"

  typedef enum logic [1:0] {
    DRLC_OFF   = 2'b00,
    DRLC_DELAY = 2'b01,
    DRLC_RUN   = 2'b10
  } drlc_pwr_e;

  // System clock domain state
  typedef struct packed {
    drlc_pwr_e        pst;
    logic             sup_s1;
    logic             sup_s2;
    logic             lat_s1;
    logic             lat_s2;
    logic             tg_s1;
    logic             tg_s2;
    logic             tg_d;
    logic [11:0]      dly;
    logic             ok;
    logic [1:0][11:0] pdac;
    logic [1:0][11:0] adac;
    logic [3:0]       pvref;
    logic [3:0]       avref;
    logic [3:0]       ppd;
    logic [3:0]       apd;
    logic [1:0]       pgain;
    logic [1:0]       again;
    logic             por;
    logic             cmd_err;
    logic [4:0]       ptr;
    logic [1:0]       pd_1k;
    logic [1:0]       pd_100k;
    logic [1:0]       pd_open;
    logic             ref_in;
    logic             ref_out;
  } drlc_core_s;

  // Serial clock domain, cleared whenever select is released
  typedef struct packed {
    logic [4:0]  cnt;
    logic [22:0] sh;
    logic [15:0] osh;
    logic        rd;
  } drlc_frame_s;

  // Serial clock domain, survives between frames
  typedef struct packed {
    logic [23:0] word;
    logic        tog;
    logic        ok_s1;
    logic        ok_s2;
  } drlc_hold_s;

  // Falling edge serial output stage
  typedef struct packed {
    logic sdo;
    logic oe;
  } drlc_sdo_s;
endpackage

// File: logic/drlc_top.sv
// Supply reset sequencing, latch transfer and serial gating of the DAC
`timescale 1ns/10ps
`include "drlc_regs.svh"

module drlc_top
  import drlc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        supply_above_trip_i,
  input  wire logic        output_latch_strobe_i,
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic [11:0]      dac0_code_o,
  output logic [11:0]      dac1_code_o,
  output logic [3:0]       ref_select_field_o,
  output logic [3:0]       powerdown_select_field_o,
  output logic [1:0]       gain_select_bit_o,
  output logic [1:0]       pulldown_1k_o,
  output logic [1:0]       pulldown_100k_o,
  output logic [1:0]       output_open_o,
  output logic             ref_pin_input_o,
  output logic             ref_pin_output_o,
  output logic             por_flag_o,
  output logic             command_error_o,
  output logic             serial_ready_o,
  output logic [4:0]       addr_ptr_o
);

  localparam logic [11:0] DLY_LAST = 12'(`DRLC_RESET_DELAY_CYC - 1);

  drlc_core_s  q, next_q;
  drlc_frame_s fq, next_fq;
  drlc_hold_s  hq, next_hq;
  drlc_sdo_s   sq, next_sq;

  logic [7:0]  cmd_byte;
  logic [15:0] rd_val;
  logic        new_cmd;
  logic [4:0]  c_addr;
  logic [1:0]  c_cmd;
  logic [15:0] c_data;
  logic        c_valid;

  // ----------------------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------------------

  // slave only, every shift edge comes from sck_i
  assign cmd_byte = {fq.sh[6:0], sdi_i};

  // each location answers as one 16-bit word, reserved reads 0
  always_comb begin
    case (cmd_byte[7:3])
      `DRLC_ADDR_DAC0: rd_val = {4'h0, q.pdac[0]};
      `DRLC_ADDR_DAC1: rd_val = {4'h0, q.pdac[1]};
      `DRLC_ADDR_VREF: rd_val = {12'h000, q.pvref};
      `DRLC_ADDR_PD:   rd_val = {12'h000, q.ppd};
      `DRLC_ADDR_GAIN: rd_val = {6'h00, q.pgain, q.por, 7'h00};
      default:         rd_val = 16'h0000;
    endcase
  end

  // Bit counter and shifters; wraps so frames may run back to back
  always_comb begin
    next_fq     = fq;
    next_fq.cnt = (fq.cnt == 5'd23) ? 5'd0 : 5'(fq.cnt + 5'd1);
    next_fq.sh  = {fq.sh[21:0], sdi_i};
    next_fq.osh = {fq.osh[14:0], 1'b0};
    if (fq.cnt == 5'd7) begin
      next_fq.rd  = (cmd_byte[2:1] == `DRLC_CMD_READ);
      next_fq.osh = (next_fq.rd && hq.ok_s2) ? rd_val : 16'h0000;
    end
  end

  // released select clears the frame, no partial command survives
  always_ff @(posedge sck_i or negedge arst_n_i or posedge cs_n_i) begin
    if (!arst_n_i || cs_n_i) begin
      fq <= '0;
    end else begin
      fq <= next_fq;
    end
  end

  // Completed word is held and announced by a toggle
  always_comb begin
    next_hq       = hq;
    next_hq.ok_s1 = q.ok;
    next_hq.ok_s2 = hq.ok_s1;
    if (fq.cnt == 5'd23) begin
      next_hq.word = {fq.sh, sdi_i};
      next_hq.tog  = ~hq.tog;
    end
  end

  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hq <= '0;
    end else begin
      hq <= next_hq;
    end
  end

  // Output changes on the falling edge so the host samples it rising
  always_comb begin
    next_sq     = sq;
    next_sq.sdo = fq.osh[15];
    next_sq.oe  = fq.rd;
  end

  always_ff @(negedge sck_i or negedge arst_n_i or posedge cs_n_i) begin
    if (!arst_n_i || cs_n_i) begin
      sq <= '0;
    end else begin
      sq <= next_sq;
    end
  end

  // ----------------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------------

  // Word is stable for a whole frame after its toggle, far longer than
  // the three cycles the toggle needs to cross
  assign new_cmd = q.tg_s2 ^ q.tg_d;
  assign c_addr  = hq.word[23:19];
  assign c_cmd   = hq.word[18:17];
  assign c_data  = hq.word[15:0];

  // only five locations exist, the rest are reserved
  always_comb begin
    case (c_addr)
      `DRLC_ADDR_DAC0, `DRLC_ADDR_DAC1, `DRLC_ADDR_VREF,
      `DRLC_ADDR_PD, `DRLC_ADDR_GAIN: c_valid = 1'b1;
      default:                        c_valid = 1'b0;
    endcase
  end

  always_comb begin
    next_q        = q;
    next_q.sup_s2 = q.sup_s1;
    next_q.sup_s1 = supply_above_trip_i;
    next_q.lat_s2 = q.lat_s1;
    next_q.lat_s1 = output_latch_strobe_i;
    next_q.tg_s2  = q.tg_s1;
    next_q.tg_s1  = hq.tog;
    next_q.tg_d   = q.tg_s2;
    // output load per channel from the active power-down field
    for (int c = 0; c < 2; c++) begin
      // 01 is 1k, 10 is 100k, 11 is open
      next_q.pd_1k[c]   = (q.apd[2*c +: 2] == `DRLC_PD_1K);
      next_q.pd_100k[c] = (q.apd[2*c +: 2] == `DRLC_PD_100K);
      next_q.pd_open[c] = (q.apd[2*c +: 2] == `DRLC_PD_OPEN);
    end
    // external codes make the pin an input, band gap drives it
    next_q.ref_in  = q.avref[1] | q.avref[3];
    next_q.ref_out = (q.avref[1:0] == `DRLC_REF_BANDGAP) |
                     (q.avref[3:2] == `DRLC_REF_BANDGAP);
    case (q.pst)
      DRLC_OFF: begin
        if (q.sup_s2) begin
          next_q.pdac  = {`DRLC_DAC_MID, `DRLC_DAC_MID};
          next_q.adac  = {`DRLC_DAC_MID, `DRLC_DAC_MID};
          next_q.pvref = `DRLC_CFG_ZERO;
          next_q.avref = `DRLC_CFG_ZERO;
          next_q.ppd   = `DRLC_CFG_ZERO;
          next_q.apd   = `DRLC_CFG_ZERO;
          next_q.pgain = 2'b00;
          next_q.again = 2'b00;
          next_q.por     = 1'b1;
          next_q.ptr     = 5'h00;
          next_q.cmd_err = 1'b0;
          next_q.dly     = 12'h000;
          next_q.pst     = DRLC_DELAY;
        end
      end
      DRLC_DELAY: begin
        // port stays closed until the delay count runs out
        next_q.dly = 12'(q.dly + 12'h001);
        if (q.dly == DLY_LAST) begin
          next_q.pst = DRLC_RUN;
          next_q.ok  = 1'b1;
        end
      end
      DRLC_RUN: begin
        // commands served at any supply above the trip level
        if (new_cmd) begin
          if (!c_valid || (c_cmd != `DRLC_CMD_WRITE &&
                           c_cmd != `DRLC_CMD_READ)) begin
            next_q.cmd_err = 1'b1;
          end else begin
            next_q.cmd_err = 1'b0;
            next_q.ptr     = c_addr;
            if (c_cmd == `DRLC_CMD_WRITE) begin
              case (c_addr)
                `DRLC_ADDR_DAC0: next_q.pdac[0] = c_data[11:0];
                `DRLC_ADDR_DAC1: next_q.pdac[1] = c_data[11:0];
                `DRLC_ADDR_VREF: next_q.pvref   = c_data[3:0];
                `DRLC_ADDR_PD:   next_q.ppd     = c_data[3:0];
                `DRLC_ADDR_GAIN: begin
                  next_q.pgain = c_data[`DRLC_GS_GAIN_LSB +: 2];
                  // Status flag clears only by writing a zero to it
                  if (!c_data[`DRLC_GS_POR_BIT]) begin
                    next_q.por = 1'b0;
                  end
                end
                default: next_q.cmd_err = 1'b1;
              endcase
            end
          end
        end
      end
      default: next_q.pst = DRLC_OFF;
    endcase
    // latch level passes pending values to the active set
    if (q.lat_s2 && q.pst != DRLC_OFF) begin
      next_q.adac  = next_q.pdac;
      next_q.avref = next_q.pvref;
      next_q.apd   = next_q.ppd;
      next_q.again = next_q.pgain;
    end
    // falling supply crossing is a brown-out and overrides state, latch and field writes, but not ptr, cmd_err or por
    if (q.pst != DRLC_OFF && !q.sup_s2) begin
      next_q.pst = DRLC_OFF;
      // port off, every channel open and powered down
      next_q.ok  = 1'b0;
      next_q.ppd = `DRLC_PD_FORCED;
      next_q.apd = `DRLC_PD_FORCED;
      next_q.pdac = {`DRLC_DAC_ZERO, `DRLC_DAC_ZERO};
      next_q.adac = {`DRLC_DAC_ZERO, `DRLC_DAC_ZERO};
      next_q.pvref = `DRLC_CFG_ZERO;
      next_q.avref = `DRLC_CFG_ZERO;
      next_q.pgain = 2'b00;
      next_q.again = 2'b00;
    end
  end

  // Reset puts the block in the browned-out state until supply is seen
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q       <= '0;
      q.pst   <= DRLC_OFF;
      q.ppd   <= `DRLC_PD_FORCED;
      q.apd   <= `DRLC_PD_FORCED;
      q.pd_open <= 2'b11;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sdo_o                    = sq.sdo;
  assign sdo_oe_o                 = sq.oe;
  assign dac0_code_o              = q.adac[0];
  assign dac1_code_o              = q.adac[1];
  assign ref_select_field_o       = q.avref;
  assign powerdown_select_field_o = q.apd;
  assign gain_select_bit_o        = q.again;
  assign pulldown_1k_o            = q.pd_1k;
  assign pulldown_100k_o          = q.pd_100k;
  assign output_open_o            = q.pd_open;
  assign ref_pin_input_o          = q.ref_in;
  assign ref_pin_output_o         = q.ref_out;
  assign por_flag_o               = q.por;
  assign command_error_o          = q.cmd_err;
  assign serial_ready_o           = q.ok;
  assign addr_ptr_o               = q.ptr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_por_start;
    q.pst == DRLC_OFF && q.sup_s2;
  endsequence

  sequence s_por_loaded;
    q.pst == DRLC_DELAY && q.por && q.ptr == 5'h00 && !q.ok &&
    q.adac[0] == `DRLC_DAC_MID && q.pdac[1] == `DRLC_DAC_MID;
  endsequence

  a_por_defaults: assert property (
    s_por_start |=> s_por_loaded)
    else $error("power-on did not load defaults");

  a_por_flag_ptr: assert property (
    s_por_start |=> q.por && q.ptr == 5'h00 && q.apd == 4'h0)
    else $error("power-on flag or pointer wrong");

  a_delay_gate: assert property (
    q.pst == DRLC_DELAY && q.sup_s2 && q.dly == DLY_LAST
    |=> q.ok && q.pst == DRLC_RUN)
    else $error("reset delay end not taken");

  a_cmd_blocked: assert property (
    new_cmd && q.pst == DRLC_DELAY && q.sup_s2
    |=> $stable(q.pdac) && $stable(q.cmd_err))
    else $error("command accepted during reset delay");

  a_bor_forces: assert property (
    q.pst != DRLC_OFF && !q.sup_s2
    |=> !q.ok && q.apd == `DRLC_PD_FORCED && q.adac == '0 &&
        q.avref == 4'h0 && q.again == 2'b00 ##1 q.pd_open == 2'b11)
    else $error("brown-out did not force outputs");

  a_latch_copy: assert property (
    q.lat_s2 && q.pst == DRLC_RUN && q.sup_s2 && !new_cmd
    |=> q.adac == $past(q.pdac) && q.apd == $past(q.ppd))
    else $error("latch did not transfer values");

  a_latch_hold: assert property (
    !q.lat_s2 && q.pst == DRLC_RUN && q.sup_s2
    |=> $stable(q.adac) && $stable(q.avref) && $stable(q.again))
    else $error("active value moved without latch");

  a_reserved_err: assert property (
    new_cmd && q.pst == DRLC_RUN && q.sup_s2 && !c_valid
    |=> q.cmd_err)
    else $error("reserved access raised no error");

  a_pd_load: assert property (
    q.apd[1:0] == `DRLC_PD_1K |=> q.pd_1k[0] && !q.pd_open[0])
    else $error("pull-down select not applied");

  a_ref_dir: assert property (
    q.avref[1:0] == `DRLC_REF_BANDGAP && !q.avref[3]
    |=> q.ref_out && !q.ref_in)
    else $error("reference pin direction wrong");

endmodule

// File: sim/drlc_spi_host.sv
// Behavioural serial host that frames 24-bit commands to the block
`timescale 1ns/10ps

module drlc_spi_host (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  // Data bits seen with the output enable high in the last frame
  int oe_cnt = 0;
  // Idle: clock low, select released
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // One frame, MSB first; sel low clocks the bits with select left high
  task automatic xfer(input logic sel, input logic [23:0] w,
                      output logic [15:0] q);
    int b;
    q = 16'h0000;
    oe_cnt = 0;
    // select held for the whole command
    cs_n_o = ~sel;
    #21.3;
    for (b = 23; b >= 0; b--) begin
      sdi_o = w[b];
      #24;
      // host alone makes the serial clock
      sck_o = 1'b1;
      if (b < 16) begin
        q[b] = sdo_i;
        if (sdo_oe_i === 1'b1) begin
          oe_cnt++;
        end
      end
      #24;
      sck_o = 1'b0;
    end
    #30;
    cs_n_o = 1'b1;
    // Released line shows the inverse, so stale data never looks valid
    sdi_o = ~sdi_o;
  endtask
endmodule

// File: sim/dac_reset_latch_control_tb_top.sv
// Self-checking bench for supply reset, latch and serial gating
`timescale 1ns/10ps
`include "drlc_regs.svh"

module dac_reset_latch_control_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        supply = 1'b0;
  logic        latch = 1'b0;
  logic        sck, cs_n, sdi, sdo, sdo_oe;
  logic [11:0] dac0, dac1;
  logic [3:0]  vref, pd;
  logic [1:0]  gain, pd1k, pd100k, popen;
  logic        ref_in, ref_out, por, cerr, ready;
  logic [4:0]  ptr;
  logic [15:0] rd, v0, v1;
  logic [3:0]  rv, rp;
  logic [1:0]  rg;
  logic [15:0] e0, e1, ecfg;
  logic [4:0]  resv [4] = '{5'h02, 5'h07, 5'h0b, 5'h1f};
  int          n_fail = 0;
  int          tests_run = 0;
  int          i, k, sd;

  always #2 clk = ~clk;

  drlc_top uut (.clk_i(clk), .arst_n_i(arst_n), .supply_above_trip_i(supply),
    .output_latch_strobe_i(latch), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .dac0_code_o(dac0), .dac1_code_o(dac1),
    .ref_select_field_o(vref), .powerdown_select_field_o(pd),
    .gain_select_bit_o(gain), .pulldown_1k_o(pd1k),
    .pulldown_100k_o(pd100k), .output_open_o(popen),
    .ref_pin_input_o(ref_in), .ref_pin_output_o(ref_out),
    .por_flag_o(por), .command_error_o(cerr), .serial_ready_o(ready),
    .addr_ptr_o(ptr));

  drlc_spi_host host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
    .sdo_oe_i(sdo_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Per-channel match of a two-bit field against one code
  function automatic logic [15:0] f_dec(input logic [3:0] f,
                                        input logic [1:0] c);
    return {14'h0, f[3:2] == c, f[1:0] == c};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write or read one location; the wait covers sync, apply and decode
  task automatic xf(input logic [4:0] a, input logic [1:0] c,
                    input logic [15:0] d);
    host.xfer(1'b1, {a, c, 1'b0, d}, rd);
    cyc(12);
  endtask

  task automatic set_in(input logic s, input logic l);
    @(posedge clk);
    supply <= s;
    latch <= l;
    cyc(6);
  endtask

  task automatic chk_off();
    chk("dac0", 16'h0000, {4'h0, dac0});
    chk("dac1", 16'h0000, {4'h0, dac1});
    chk("pd", 16'h000f, {12'h0, pd});
    chk("open", 16'h0003, {14'h0, popen});
    chk("vref", 16'h0000, {12'h0, vref});
    chk("gain", 16'h0000, {14'h0, gain});
    chk("ready", 16'h0000, {15'h0, ready});
  endtask

  task automatic chk_por();
    chk("dac0", 16'h07ff, {4'h0, dac0});
    chk("dac1", 16'h07ff, {4'h0, dac1});
    chk("cfg", 16'h0000, {vref, pd, 6'h0, gain});
    chk("por", 16'h0001, {15'h0, por});
    chk("ptr", 16'h0000, {11'h0, ptr});
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sd = $urandom(32'h6e69);
    cyc(5);
    arst_n <= 1'b1;
    cyc(2);
    chk_off();
    $display("Test reset state done");
    // Power-on; a write during the delay must be dropped
    set_in(1'b1, 1'b1);
    chk_por();
    xf(`DRLC_ADDR_DAC0, `DRLC_CMD_WRITE, 16'h0123);
    chk("dac0_dly", 16'h07ff, {4'h0, dac0});
    k = 0;
    while (ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      final_report();
    end
    // About 320 cycles of the delay were spent on the dropped write
    chk("delay", 16'h0001, {15'h0, k >= `DRLC_RESET_DELAY_CYC - 400});
    // First read is not checked; ready crosses to the serial side in its first two clock edges
    xf(`DRLC_ADDR_GAIN, `DRLC_CMD_READ, 16'h0);
    xf(`DRLC_ADDR_GAIN, `DRLC_CMD_READ, 16'h0);
    chk("gs_rd", 16'h0080, rd);
    chk("oe_rd", 16'h0010, 16'(host.oe_cnt));
    $display("Test power-on done");
    // Latch held low hides writes; pass 0 is full and zero scale
    e0 = 16'h07ff;
    e1 = 16'h07ff;
    ecfg = 16'h0000;
    for (i = 0; i < 2; i++) begin
      v0 = (i == 0) ? 16'h0fff : {4'h0, 12'($urandom)};
      v1 = (i == 0) ? 16'h0000 : {4'h0, 12'($urandom)};
      rv = (i == 0) ? 4'hf : 4'($urandom);
      rp = (i == 0) ? 4'h0 : 4'($urandom);
      rg = (i == 0) ? 2'h3 : 2'($urandom);
      set_in(1'b1, 1'b0);
      xf(`DRLC_ADDR_DAC0, `DRLC_CMD_WRITE, v0);
      xf(`DRLC_ADDR_DAC1, `DRLC_CMD_WRITE, v1);
      xf(`DRLC_ADDR_VREF, `DRLC_CMD_WRITE, {12'h0, rv});
      xf(`DRLC_ADDR_PD, `DRLC_CMD_WRITE, {12'h0, rp});
      xf(`DRLC_ADDR_GAIN, `DRLC_CMD_WRITE, {6'h0, rg, 8'h80});
      chk("held0", e0, {4'h0, dac0});
      chk("held1", e1, {4'h0, dac1});
      chk("held_cfg", ecfg, {vref, pd, 6'h0, gain});
      set_in(1'b1, 1'b1);
      chk("dac0", v0, {4'h0, dac0});
      chk("dac1", v1, {4'h0, dac1});
      chk("cfg", {rv, rp, 6'h0, rg}, {vref, pd, 6'h0, gain});
      e0 = v0;
      e1 = v1;
      ecfg = {rv, rp, 6'h0, rg};
      xf(`DRLC_ADDR_DAC1, `DRLC_CMD_READ, 16'h0);
      chk("dac1_rd", v1, rd);
    end
    $display("Test latch transfer done");
    // Every power-down and reference code, power-down channels differing, reference channels equal
    for (i = 0; i < 4; i++) begin
      rp = {2'(3 - i), 2'(i)};
      xf(`DRLC_ADDR_PD, `DRLC_CMD_WRITE, {12'h0, rp});
      xf(`DRLC_ADDR_VREF, `DRLC_CMD_WRITE, {12'h0, 2'(i), 2'(i)});
      chk("pd1k", f_dec(rp, 2'b01), {14'h0, pd1k});
      chk("pd100k", f_dec(rp, 2'b10), {14'h0, pd100k});
      chk("open", f_dec(rp, 2'b11), {14'h0, popen});
      chk("ref_in", {15'h0, i >= 2}, {15'h0, ref_in});
      chk("ref_out", {15'h0, i == 1}, {15'h0, ref_out});
    end
    $display("Test field decode done");
    // Reserved locations flag an error; a valid access clears it
    for (i = 0; i < 4; i++) begin
      xf(resv[i], `DRLC_CMD_WRITE, 16'hffff);
      chk("err_wr", 16'h0001, {15'h0, cerr});
      xf(resv[i], `DRLC_CMD_READ, 16'h0);
      chk("resv_rd", 16'h0000, rd);
      chk("err_rd", 16'h0001, {15'h0, cerr});
      xf(`DRLC_ADDR_DAC1, `DRLC_CMD_READ, 16'h0);
      chk("err_clr", 16'h0000, {15'h0, cerr});
      chk("ptr", 16'h0001, {11'h0, ptr});
      chk("dac1_kept", v1, {4'h0, dac1});
    end
    $display("Test reserved access done");
    // Bits clocked with select released change nothing
    host.xfer(1'b0, {`DRLC_ADDR_DAC0, `DRLC_CMD_WRITE, 1'b0, 16'h0abc}, rd);
    cyc(12);
    chk("cs_off", v0, {4'h0, dac0});
    xf(`DRLC_ADDR_GAIN, `DRLC_CMD_WRITE, 16'h0000);
    chk("por_clr", 16'h0000, {15'h0, por});
    chk("oe_wr", 16'h0000, 16'(host.oe_cnt));
    $display("Test select gating done");
    // Brown-out then recovery, pointer left non-zero before
    set_in(1'b0, 1'b1);
    chk_off();
    set_in(1'b1, 1'b1);
    chk_por();
    $display("Test brown-out done");
    final_report();
  end
endmodule
